/* File: rtl/scd_pkg.sv */
// scd_pkg: command codes, decode actions and field positions for the
// secondary-side command decoder; shared by the decoder and its helper.
package scd_pkg;
  // bus command codes as seen on the inverted command/byte-enable lines
  localparam logic [3:0] SCD_CMD_INTACK   = 4'h0;
  localparam logic [3:0] SCD_CMD_SPECIAL  = 4'h1;
  localparam logic [3:0] SCD_CMD_IO_RD    = 4'h2;
  localparam logic [3:0] SCD_CMD_IO_WR    = 4'h3;
  localparam logic [3:0] SCD_CMD_RSVD4    = 4'h4;
  localparam logic [3:0] SCD_CMD_RSVD5    = 4'h5;
  localparam logic [3:0] SCD_CMD_MEM_RD   = 4'h6;
  localparam logic [3:0] SCD_CMD_MEM_WR   = 4'h7;
  localparam logic [3:0] SCD_CMD_ALIAS_RB = 4'h8;
  localparam logic [3:0] SCD_CMD_ALIAS_WB = 4'h9;
  localparam logic [3:0] SCD_CMD_CFG_RD   = 4'hA;
  localparam logic [3:0] SCD_CMD_CFG_WR   = 4'hB;
  localparam logic [3:0] SCD_CMD_MRM_SC   = 4'hC;
  localparam logic [3:0] SCD_CMD_DAC      = 4'hD;
  localparam logic [3:0] SCD_CMD_MRL_RB   = 4'hE;
  localparam logic [3:0] SCD_CMD_MWI_WB   = 4'hF;

  // special-cycle request signature in a type 1 config address
  localparam logic [4:0] SCD_SC_DEVICE    = 5'h1F;
  localparam logic [2:0] SCD_SC_FUNCTION  = 3'h7;
  localparam int         SCD_CFG_TYPE_BIT = 0;
  localparam int         SCD_FUNC_LSB     = 8;
  localparam int         SCD_DEV_LSB      = 11;
  localparam int         SCD_BUS_LSB      = 16;

  // decode result
  typedef enum logic [4:0] {
    SCD_ACT_IGNORE  = 5'b00001,
    SCD_ACT_LOCAL   = 5'b00010,
    SCD_ACT_FORWARD = 5'b00100,
    SCD_ACT_SPECIAL = 5'b01000,
    SCD_ACT_CFG1    = 5'b10000
  } scd_action_e;

  // effective command class after aliasing
  typedef enum logic [5:0] {
    SCD_CLS_NONE    = 6'b000001,
    SCD_CLS_IO      = 6'b000010,
    SCD_CLS_MEM     = 6'b000100,
    SCD_CLS_BLOCK   = 6'b001000,
    SCD_CLS_SPLIT   = 6'b010000,
    SCD_CLS_CFGWR   = 6'b100000
  } scd_class_e;

  // decoder phase
  typedef enum logic [2:0] {
    SCD_ST_IDLE  = 3'b001,
    SCD_ST_DAC   = 3'b010,
    SCD_ST_HOLD  = 3'b100
  } scd_state_e;

  localparam logic [3:0] SCD_CMD_RESET = 4'hF;
endpackage

/* File: rtl/scd_window_hit.sv */
// scd_window_hit: inclusive base/limit compare of one AW-bit address (64 by default).
// assumes base and limit are stable configuration levels.
`timescale 1ns/1ns
module scd_window_hit
  import scd_pkg::*;
#(
  parameter int AW = 64
) (
  // window
  input  wire logic [AW-1:0] base_i,
  input  wire logic [AW-1:0] limit_i,
  input  wire logic          enable_i,
  // probe
  input  wire logic [AW-1:0] addr_i,
  output      logic          hit_o
);
  if (AW < 32) begin : g_bad_aw
    $error("scd_window_hit: AW below 32");
  end

  wire above_base = addr_i >= base_i;
  wire below_lim  = addr_i <= limit_i;
  assign hit_o = enable_i && above_base && below_lim;
endmodule

/* File: rtl/scd_decoder.sv */
// scd_decoder: decodes the command of a secondary-bus master and decides
// whether the bridge ignores, claims locally, forwards, or remaps it.
// assumes address phase strobe from same-clock bus front end; mode and
// window settings are levels from the configuration space (pins here).
// Contract
// - I/O cycles: window forwards, register claims, else ignore
// - memory cycles: window forwards, register claims, else ignore
// - 1000b unsupported conventional; PCI-X memory read block
// - 1001b unsupported conventional; PCI-X memory write block
// - config reads from downstream never supported nor forwarded
// - type 0 and plain type 1 writes unsupported
// - special-cycle request to primary bus becomes special cycle
// - foreign bus request forwarded unchanged as type 1
// - request targeting a downstream bus is ignored
// - 1100b memory read conventional, split completion PCI-X
// - 1110b memory read conventional, read block PCI-X
// - 1111b memory write conventional, write block PCI-X
// - dual address: low 32 bits first, then high
`timescale 1ns/1ns
module scd_decoder
  import scd_pkg::*;
#(
  parameter int AW = 64
) (
  // clock, reset, enable
  input  wire logic          CLOCK_I,
  input  wire logic          SYS_RST_I,
  input  wire logic          CLK_EN_I,
  // bus mode, level from pin
  input  wire logic          PCIX_MODE_I,
  // address phase from secondary front end
  input  wire logic          ADDR_VALID_I,
  input  wire logic [3:0]    DOWNSTREAM_CMD_BYTE_ENABLE_N_I,
  input  wire logic [31:0]   AD_I,
  // windows and bus numbers
  input  wire logic [AW-1:0] IO_BASE_I,
  input  wire logic [AW-1:0] IO_LIMIT_I,
  input  wire logic          IO_EN_I,
  input  wire logic [AW-1:0] MEM_BASE_I,
  input  wire logic [AW-1:0] MEM_LIMIT_I,
  input  wire logic          MEM_EN_I,
  input  wire logic [AW-1:0] IO_REG_BASE_I,
  input  wire logic [AW-1:0] IO_REG_LIMIT_I,
  input  wire logic [AW-1:0] MEM_REG_BASE_I,
  input  wire logic [AW-1:0] MEM_REG_LIMIT_I,
  input  wire logic [7:0]    PRIMARY_BUS_I,
  input  wire logic [7:0]    SECONDARY_BUS_I,
  input  wire logic [7:0]    SUBORDINATE_BUS_I,
  // decision
  output      logic          DECODE_VALID_O,
  output      logic          CLAIM_O,
  output      logic [4:0]    ACTION_O,
  output      logic [3:0]    FWD_CMD_O,
  output      logic [AW-1:0] ADDR_O,
  output      logic          DAC_O
);
  if (AW != 64 && AW != 32) begin : g_bad_aw
    $error("scd_decoder: AW must be 32 or 64");
  end

  // pin-sourced mode level passes two flops
  logic       mode_meta;
  logic       pcix;
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      mode_meta <= 1'b0;
      pcix      <= 1'b0;
    end else if (CLK_EN_I) begin
      mode_meta <= PCIX_MODE_I;
      pcix      <= mode_meta;
    end
  end

  // command is active low on the wire
  wire [3:0] cmd_raw = ~DOWNSTREAM_CMD_BYTE_ENABLE_N_I;

  scd_state_e state;
  scd_state_e next_state;
  logic [31:0] dac_low;

  wire start    = ADDR_VALID_I && (state == SCD_ST_IDLE);
  wire is_dac   = start && (cmd_raw == SCD_CMD_DAC);
  wire dac_done = ADDR_VALID_I && (state == SCD_ST_DAC);
  wire go       = (start && !is_dac) || dac_done;

  // second phase of a dual address carries the real command
  wire [3:0]  eff_cmd  = cmd_raw;
  wire [AW-1:0] addr_full;
  generate
    if (AW == 64) begin : g_a64
      assign addr_full = dac_done ? {AD_I, dac_low} : {32'h0000_0000, AD_I};
    end else begin : g_a32
      assign addr_full = AD_I;
    end
  endgenerate

  // command class after mode aliasing
  scd_class_e cls;
  logic [3:0] fwd_cmd;
  always_comb begin
    cls     = SCD_CLS_NONE;
    fwd_cmd = eff_cmd;
    unique case (eff_cmd)
      SCD_CMD_IO_RD, SCD_CMD_IO_WR: begin
        cls = SCD_CLS_IO;
      end
      SCD_CMD_MEM_RD, SCD_CMD_MEM_WR: begin
        cls = SCD_CLS_MEM;
      end
      SCD_CMD_ALIAS_RB: begin
        cls     = pcix ? SCD_CLS_BLOCK : SCD_CLS_NONE;
        fwd_cmd = SCD_CMD_MRL_RB;
      end
      SCD_CMD_ALIAS_WB: begin
        cls     = pcix ? SCD_CLS_BLOCK : SCD_CLS_NONE;
        fwd_cmd = SCD_CMD_MWI_WB;
      end
      SCD_CMD_MRM_SC: begin
        cls     = pcix ? SCD_CLS_SPLIT : SCD_CLS_MEM;
        fwd_cmd = pcix ? SCD_CMD_MRM_SC : SCD_CMD_MEM_RD;
      end
      SCD_CMD_MRL_RB: begin
        cls     = pcix ? SCD_CLS_BLOCK : SCD_CLS_MEM;
        fwd_cmd = pcix ? SCD_CMD_MRL_RB : SCD_CMD_MEM_RD;
      end
      SCD_CMD_MWI_WB: begin
        cls     = pcix ? SCD_CLS_BLOCK : SCD_CLS_MEM;
        fwd_cmd = pcix ? SCD_CMD_MWI_WB : SCD_CMD_MEM_WR;
      end
      SCD_CMD_CFG_WR: begin
        cls = SCD_CLS_CFGWR;
      end
      SCD_CMD_CFG_RD: begin
        cls = SCD_CLS_NONE;
      end
      default: begin
        cls = SCD_CLS_NONE;
      end
    endcase
  end

  // address windows
  logic io_fwd_hit;
  logic mem_fwd_hit;
  logic io_reg_hit;
  logic mem_reg_hit;
  scd_window_hit #(.AW(AW)) u_io_fwd (
    .base_i   (IO_BASE_I),
    .limit_i  (IO_LIMIT_I),
    .enable_i (IO_EN_I),
    .addr_i   (addr_full),
    .hit_o    (io_fwd_hit)
  );
  scd_window_hit #(.AW(AW)) u_mem_fwd (
    .base_i   (MEM_BASE_I),
    .limit_i  (MEM_LIMIT_I),
    .enable_i (MEM_EN_I),
    .addr_i   (addr_full),
    .hit_o    (mem_fwd_hit)
  );
  scd_window_hit #(.AW(AW)) u_io_reg (
    .base_i   (IO_REG_BASE_I),
    .limit_i  (IO_REG_LIMIT_I),
    .enable_i (1'b1),
    .addr_i   (addr_full),
    .hit_o    (io_reg_hit)
  );
  scd_window_hit #(.AW(AW)) u_mem_reg (
    .base_i   (MEM_REG_BASE_I),
    .limit_i  (MEM_REG_LIMIT_I),
    .enable_i (1'b1),
    .addr_i   (addr_full),
    .hit_o    (mem_reg_hit)
  );

  // config write fields
  wire [7:0] tgt_bus  = AD_I[SCD_BUS_LSB +: 8];
  wire [4:0] tgt_dev  = AD_I[SCD_DEV_LSB +: 5];
  wire [2:0] tgt_func = AD_I[SCD_FUNC_LSB +: 3];
  wire       type1    = AD_I[SCD_CFG_TYPE_BIT];
  wire       sc_req   = type1 && (tgt_dev == SCD_SC_DEVICE) && (tgt_func == SCD_SC_FUNCTION);
  wire       to_prim  = tgt_bus == PRIMARY_BUS_I;
  wire       in_range = (tgt_bus >= SECONDARY_BUS_I) && (tgt_bus <= SUBORDINATE_BUS_I);

  // forwarding wins over a register hit: the window owns its space
  scd_action_e act;
  always_comb begin
    act = SCD_ACT_IGNORE;
    unique case (cls)
      SCD_CLS_IO: begin
        if (io_fwd_hit) begin
          act = SCD_ACT_FORWARD;
        end else if (io_reg_hit) begin
          act = SCD_ACT_LOCAL;
        end
      end
      SCD_CLS_MEM, SCD_CLS_BLOCK: begin
        if (mem_fwd_hit) begin
          act = SCD_ACT_FORWARD;
        end else if (mem_reg_hit) begin
          act = SCD_ACT_LOCAL;
        end
      end
      SCD_CLS_SPLIT: begin
        // split completions are routed by their requester, forward all
        act = SCD_ACT_FORWARD;
      end
      SCD_CLS_CFGWR: begin
        if (!sc_req || dac_done) begin
          act = SCD_ACT_IGNORE;
        end else if (to_prim) begin
          act = SCD_ACT_SPECIAL;
        end else if (!in_range) begin
          act = SCD_ACT_CFG1;
        end else begin
          act = SCD_ACT_IGNORE;
        end
      end
      SCD_CLS_NONE: begin
        act = SCD_ACT_IGNORE;
      end
    endcase
  end

  wire [3:0] out_cmd = (act == SCD_ACT_SPECIAL) ? SCD_CMD_SPECIAL : fwd_cmd;

  // phase tracking: dual address holds the low half until the high phase arrives
  always_comb begin
    next_state = state;
    unique case (state)
      SCD_ST_IDLE: begin
        if (is_dac) begin
          next_state = SCD_ST_DAC;
        end else if (go) begin
          next_state = SCD_ST_HOLD;
        end
      end
      SCD_ST_DAC: begin
        if (dac_done) begin
          next_state = SCD_ST_HOLD;
        end
      end
      SCD_ST_HOLD: begin
        next_state = SCD_ST_IDLE;
      end
      default: begin
        next_state = SCD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state   <= SCD_ST_IDLE;
      dac_low <= 32'h0000_0000;
    end else if (CLK_EN_I) begin
      state <= next_state;
      if (is_dac) begin
        dac_low <= AD_I;
      end
    end
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      DECODE_VALID_O <= 1'b0;
      CLAIM_O        <= 1'b0;
      ACTION_O       <= SCD_ACT_IGNORE;
      FWD_CMD_O      <= SCD_CMD_RESET;
      ADDR_O         <= '0;
      DAC_O          <= 1'b0;
    end else if (CLK_EN_I) begin
      DECODE_VALID_O <= go;
      if (go) begin
        CLAIM_O   <= act != SCD_ACT_IGNORE;
        ACTION_O  <= act;
        FWD_CMD_O <= out_cmd;
        ADDR_O    <= addr_full;
        DAC_O     <= dac_done;
      end else begin
        CLAIM_O <= 1'b0;
      end
    end
  end
endmodule

/* File: test/scd_decoder_props.sv */
// scd_decoder_props: port-level checks of the secondary command decoder.
// assumes CLK_EN_I held high and single address phases spaced by idle cycles.
`timescale 1ns/1ns
module scd_decoder_props
  import scd_pkg::*;
#(
  parameter int AW = 64
) (
  input wire logic          CLOCK_I,
  input wire logic          SYS_RST_I,
  input wire logic          PCIX_MODE_I,
  input wire logic          ADDR_VALID_I,
  input wire logic [3:0]    DOWNSTREAM_CMD_BYTE_ENABLE_N_I,
  input wire logic [31:0]   AD_I,
  input wire logic [7:0]    PRIMARY_BUS_I,
  input wire logic          DECODE_VALID_O,
  input wire logic          CLAIM_O,
  input wire logic [4:0]    ACTION_O,
  input wire logic [3:0]    FWD_CMD_O,
  input wire logic [AW-1:0] ADDR_O,
  input wire logic          DAC_O
);
  logic [1:0] mode_q;
  logic [3:0] cmd;
  logic       px;
  logic       cv;
  logic       sc;
  assign cmd = ~DOWNSTREAM_CMD_BYTE_ENABLE_N_I;
  // mode only trusted once it has settled through the two sync flops
  assign px  = &{mode_q, PCIX_MODE_I};
  assign cv  = ~|{mode_q, PCIX_MODE_I};
  assign sc  = AD_I[0] && AD_I[15:8] == 8'hFF;
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) mode_q <= 2'h0;
    else mode_q <= {mode_q[0], PCIX_MODE_I};
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence s_one;
    ADDR_VALID_I && cmd != SCD_CMD_DAC && !$past(ADDR_VALID_I);
  endsequence
  sequence s_dac;
    ADDR_VALID_I && cmd == SCD_CMD_DAC && !$past(ADDR_VALID_I) ##1 ADDR_VALID_I && cmd[3:1] == 3'h3;
  endsequence
  a_pulse_once: assert property (
    s_one |=> DECODE_VALID_O ##1 !DECODE_VALID_O)
    else $error("decision pulse wrong");
  a_claim_action: assert property (
    DECODE_VALID_O |-> CLAIM_O == (ACTION_O != SCD_ACT_IGNORE))
    else $error("claim disagrees with action");
  a_never_claim: assert property (
    s_one ##0 (cmd inside {4'h0, 4'h1, 4'h4, 4'h5, 4'hA} || cmd[3:1] == 3'h4 && cv)
    |=> !CLAIM_O && ACTION_O == SCD_ACT_IGNORE)
    else $error("unsupported command claimed");
  a_alias_block: assert property (
    s_one ##0 (px && cmd[3:1] == 3'h4) |=> ACTION_O != SCD_ACT_FORWARD || FWD_CMD_O == {3'h7, $past(cmd[0])})
    else $error("alias not sent as block");
  a_conv_remap: assert property (
    s_one ##0 (cv && cmd inside {4'hC, 4'hE, 4'hF})
    |=> ACTION_O != SCD_ACT_FORWARD || FWD_CMD_O == {3'h3, $past(cmd[0])})
    else $error("conventional remap wrong");
  a_sc_primary: assert property (
    s_one ##0 (cmd == SCD_CMD_CFG_WR && sc && AD_I[23:16] == PRIMARY_BUS_I)
    |=> CLAIM_O && ACTION_O == SCD_ACT_SPECIAL && FWD_CMD_O == SCD_CMD_SPECIAL)
    else $error("special cycle request missed");
  a_cfg_plain: assert property (
    s_one ##0 (cmd == SCD_CMD_CFG_WR && !sc) |=> !CLAIM_O)
    else $error("plain config write claimed");
  a_dac_order: assert property (
    s_dac |=> DECODE_VALID_O && DAC_O && ADDR_O == {$past(AD_I), $past(AD_I, 2)} && FWD_CMD_O == $past(cmd))
    else $error("dual address assembled wrong");
endmodule

bind scd_decoder scd_decoder_props #(.AW(AW)) i_scd_decoder_props (
  .CLOCK_I, .SYS_RST_I, .PCIX_MODE_I, .ADDR_VALID_I, .DOWNSTREAM_CMD_BYTE_ENABLE_N_I, .AD_I, .PRIMARY_BUS_I,
  .DECODE_VALID_O, .CLAIM_O, .ACTION_O, .FWD_CMD_O, .ADDR_O, .DAC_O
);

/* File: test/scd_master_model.sv */
// scd_master_model: one master on the secondary bus issuing address phases.
// assumes it is the only driver of the command and address lines.
`timescale 1ns/1ns
module scd_master_model
  import scd_pkg::*;
(
  input  wire logic        clk_i,
  output      logic        valid_o,
  output      logic [3:0]  cmd_n_o,
  output      logic [31:0] ad_o
);
  initial begin
    valid_o = 1'h0;
    cmd_n_o = 4'hF;
    ad_o    = 32'h0;
  end
  task automatic put(input logic [3:0] cmd, input logic [31:0] ad);
    @(posedge clk_i);
    #1;
    valid_o = 1'h1;
    cmd_n_o = ~cmd;
    ad_o    = ad;
  endtask
  // released lines flip so a stale value never passes for a live one
  task automatic free;
    @(posedge clk_i);
    #1;
    valid_o = 1'h0;
    cmd_n_o = ~cmd_n_o;
    ad_o    = ~ad_o;
  endtask
  task automatic single(input logic [3:0] cmd, input logic [31:0] ad);
    put(cmd, ad);
    free();
  endtask
  task automatic dual(input logic [3:0] cmd, input logic [63:0] ad);
    put(SCD_CMD_DAC, ad[31:0]);
    put(cmd, ad[63:32]);
    free();
  endtask
endmodule

/* File: test/secondary_side_command_decode_tb.sv */
// secondary_side_command_decode_tb: table-driven check of the command decoder.
// assumes the master model issues phases; windows and bus numbers are levels.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module secondary_side_command_decode_tb
  import scd_pkg::*;
;
  typedef struct packed {
    logic        x;
    logic [3:0]  cmd;
    logic [31:0] ad;
    logic [4:0]  act;
    logic [3:0]  fwd;
  } scd_row_s;
  localparam logic [4:0] ig = SCD_ACT_IGNORE, lo = SCD_ACT_LOCAL, fw = SCD_ACT_FORWARD;
  localparam logic [4:0] sp = SCD_ACT_SPECIAL, c1 = SCD_ACT_CFG1;
  logic        CLOCK_I = 1'h0, SYS_RST_I = 1'h1, CLK_EN_I = 1'h1, PCIX_MODE_I = 1'h0, IO_EN_I = 1'h1, MEM_EN_I = 1'h1;
  logic [63:0] IO_BASE_I = 64'h1000, IO_LIMIT_I = 64'h1FFF, IO_REG_BASE_I = 64'h100, IO_REG_LIMIT_I = 64'h1FF;
  logic [63:0] MEM_BASE_I = 64'h10000, MEM_LIMIT_I = 64'h1_FFFF_FFFF, MEM_REG_BASE_I = 64'h100, MEM_REG_LIMIT_I = 64'h1FF;
  logic [7:0]  PRIMARY_BUS_I = 8'h01, SECONDARY_BUS_I = 8'h02, SUBORDINATE_BUS_I = 8'h05;
  logic        ADDR_VALID_I, DECODE_VALID_O, CLAIM_O, DAC_O;
  logic [3:0]  DOWNSTREAM_CMD_BYTE_ENABLE_N_I, FWD_CMD_O;
  logic [31:0] AD_I;
  logic [4:0]  ACTION_O;
  logic [63:0] ADDR_O;
  int          error_cnt = 0, checks_done = 0, cycles = 0;
  scd_row_s    rows [29] = '{
    '{1'h0,4'h2,32'h1000,fw,4'h2}, '{1'h0,4'h3,32'h0150,lo,4'h0}, '{1'h0,4'h2,32'h3000,ig,4'h0},
    '{1'h0,4'h6,32'h10000,fw,4'h6}, '{1'h0,4'h7,32'h0180,lo,4'h0}, '{1'h0,4'h6,32'h0020,ig,4'h0},
    '{1'h0,4'h8,32'h10000,ig,4'h0}, '{1'h0,4'h9,32'h10000,ig,4'h0}, '{1'h0,4'hA,32'h1FF01,ig,4'h0},
    '{1'h0,4'hB,32'h1FF00,ig,4'h0}, '{1'h0,4'hB,32'h10801,ig,4'h0}, '{1'h0,4'hB,32'h1FF01,sp,4'h1},
    '{1'h0,4'hB,32'h3FF01,ig,4'h0}, '{1'h0,4'hB,32'h6FF01,c1,4'hB}, '{1'h0,4'hC,32'h10000,fw,4'h6},
    '{1'h0,4'hE,32'h10000,fw,4'h6}, '{1'h0,4'hF,32'h10000,fw,4'h7}, '{1'h0,4'h0,32'h10000,ig,4'h0},
    '{1'h0,4'h1,32'h10000,ig,4'h0}, '{1'h0,4'h4,32'h10000,ig,4'h0}, '{1'h0,4'h5,32'h10000,ig,4'h0},
    '{1'h1,4'h3,32'h1FFF,fw,4'h3}, '{1'h1,4'h8,32'h10000,fw,4'hE}, '{1'h1,4'h9,32'h10000,fw,4'hF},
    '{1'h1,4'hC,32'h10000,fw,4'hC}, '{1'h1,4'hE,32'h10000,fw,4'hE}, '{1'h1,4'hF,32'h10000,fw,4'hF},
    '{1'h1,4'hB,32'h2FF01,ig,4'h0}, '{1'h1,4'hA,32'h1FF01,ig,4'h0}};
  scd_decoder i_scd_decoder (.CLOCK_I, .SYS_RST_I, .CLK_EN_I, .PCIX_MODE_I, .ADDR_VALID_I,
    .DOWNSTREAM_CMD_BYTE_ENABLE_N_I, .AD_I, .IO_BASE_I, .IO_LIMIT_I, .IO_EN_I, .MEM_BASE_I, .MEM_LIMIT_I,
    .MEM_EN_I, .IO_REG_BASE_I, .IO_REG_LIMIT_I, .MEM_REG_BASE_I, .MEM_REG_LIMIT_I, .PRIMARY_BUS_I,
    .SECONDARY_BUS_I, .SUBORDINATE_BUS_I, .DECODE_VALID_O, .CLAIM_O, .ACTION_O, .FWD_CMD_O, .ADDR_O, .DAC_O);
  scd_master_model i_scd_master_model (.clk_i(CLOCK_I), .valid_o(ADDR_VALID_I),
    .cmd_n_o(DOWNSTREAM_CMD_BYTE_ENABLE_N_I), .ad_o(AD_I));
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK_I);
    #1;
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always #5 CLOCK_I = ~CLOCK_I;
  // the whole run needs under 150 cycles
  always @(posedge CLOCK_I) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    tick(10);
    SYS_RST_I = 1'h0;
    tick(2);
    foreach (rows[i]) begin
      if (PCIX_MODE_I !== rows[i].x) begin
        PCIX_MODE_I = rows[i].x;
        tick(4);
      end
      i_scd_master_model.single(rows[i].cmd, rows[i].ad);
      `CHK("valid", 1'h1, DECODE_VALID_O)
      `CHK("claim", rows[i].act != ig, CLAIM_O)
      `CHK("action", rows[i].act, ACTION_O)
      if (rows[i].act != ig && rows[i].act != lo) `CHK("fwd cmd", rows[i].fwd, FWD_CMD_O)
      `CHK("addr", {32'h0, rows[i].ad}, ADDR_O)
      `CHK("single dac", 1'h0, DAC_O)
      tick(2);
    end
    i_scd_master_model.dual(SCD_CMD_MEM_WR, 64'h1_0000_0040);
    `CHK("dac addr", 64'h1_0000_0040, ADDR_O)
    `CHK("dac flag", 1'h1, DAC_O)
    `CHK("dac action", fw, ACTION_O)
    `CHK("dac cmd", SCD_CMD_MEM_WR, FWD_CMD_O)
    tick(2);
    IO_EN_I = 1'h0;
    i_scd_master_model.single(SCD_CMD_IO_RD, 32'h1000);
    `CHK("io off", ig, ACTION_O)
    tick(2);
    SYS_RST_I = 1'h1;
    tick(1);
    `CHK("rst action", ig, ACTION_O)
    `CHK("rst claim", 1'h0, CLAIM_O)
    `CHK("rst valid", 1'h0, DECODE_VALID_O)
    `CHK("rst fwd", SCD_CMD_RESET, FWD_CMD_O)
    `CHK("rst addr", 64'h0, ADDR_O)
    `CHK("rst dac", 1'h0, DAC_O)
    // decoder must take a phase again after a mid-run reset
    SYS_RST_I = 1'h0;
    tick(2);
    i_scd_master_model.single(SCD_CMD_MEM_RD, 32'h10000);
    `CHK("rerun valid", 1'h1, DECODE_VALID_O)
    `CHK("rerun action", fw, ACTION_O)
    `CHK("rerun claim", 1'h1, CLAIM_O)
    give_verdict();
  end
endmodule
